// >>> hw/fsp_pkg.sv
package fsp_pkg;

	// Instruction codes
	localparam logic [7:0] OP_WPS = 8'h06;
	localparam logic [7:0] OP_WPC = 8'h04;
	localparam logic [7:0] OP_RDST = 8'h05;
	localparam logic [7:0] OP_STW = 8'h01;
	localparam logic [7:0] OP_PGW = 8'h02;
	localparam logic [7:0] OP_RGC = 8'hd8;
	localparam logic [7:0] OP_WAC = 8'hc7;
	localparam logic [7:0] OP_SLP = 8'hb9;
	localparam logic [7:0] OP_WAKE = 8'hab;
	localparam logic [7:0] OP_OTP = 8'h3a;

	// Byte counts per instruction; the page write count is a minimum
	localparam logic [9:0] LEN_OP = 10'h001;
	localparam logic [9:0] LEN_STW = 10'h002;
	localparam logic [9:0] LEN_RGC = 10'h004;
	localparam logic [9:0] LEN_PGW_MIN = 10'h005;
	localparam logic [9:0] LEN_ID_AT = 10'h003;
	localparam logic [9:0] LEN_MAX = 10'h3ff;
	localparam logic [8:0] PAGE_FULL = 9'h100;
	localparam int PAGE_BYTES = 256;

	// Status byte field positions
	localparam int ST_WIP = 0;
	localparam int ST_WEL = 1;
	localparam int ST_GUARD = 2;
	localparam int ST_LOCK = 7;
	localparam logic [2:0] GUARD_RST = 3'h0;
	localparam logic LOCK_RST = 1'b0;

	// Internal cycle lengths in core clocks
	localparam logic [23:0] PROG_CYC_DEF = 24'h0000c8;
	localparam logic [23:0] SECT_CYC_DEF = 24'h002000;
	localparam logic [23:0] BULK_CYC_DEF = 24'h008000;
	localparam logic [23:0] STW_CYC_DEF = 24'h000100;

	// Arbitrary identification value
	localparam logic [7:0] DEV_ID_DEF = 8'h5a;

	// Input synchroniser slots and their idle levels
	localparam int SYNC_N = 5;
	localparam int SY_CLK = 0;
	localparam int SY_SEL = 1;
	localparam int SY_DIN = 2;
	localparam int SY_PAUSE = 3;
	localparam int SY_PROT = 4;
	localparam logic [4:0] SYNC_INIT = 5'h1a;

	// Buffered program word: otp flag, 24-bit address, data byte
	localparam int WORD_W = 33;

	typedef enum logic [1:0] {
		CYC_IDLE = 2'b00,
		CYC_STREAM = 2'b01,
		CYC_TIMED = 2'b11,
		CYC_DONE = 2'b10
	} fsp_cyc_t;

	typedef enum logic [1:0] {
		PWR_ACTIVE = 2'b00,
		PWR_STANDBY = 2'b01,
		PWR_SLEEP = 2'b11
	} fsp_pwr_t;

	// Address falls in the region chosen by the guard bits
	function automatic logic fsp_guarded(input logic [23:0] a, input logic [2:0] g,
		input logic top_boot);
		logic [21:0] x;
		logic hit;
		x = a[21:0];
		hit = 1'b0;
		if (top_boot)
		begin
			case (g)
				3'h1: hit = (x >= 22'h3ff000);
				3'h2: hit = (x >= 22'h3fe000);
				3'h3: hit = (x >= 22'h3fc000);
				3'h4: hit = (x >= 22'h3f8000);
				3'h5: hit = (x >= 22'h3f0000);
				3'h6: hit = (x >= 22'h200000);
				3'h7: hit = 1'b1;
				default: hit = 1'b0;
			endcase
		end
		else
		begin
			case (g)
				3'h1: hit = (x <= 22'h000fff);
				3'h2: hit = (x <= 22'h001fff);
				3'h3: hit = (x <= 22'h003fff);
				3'h4: hit = (x <= 22'h007fff);
				3'h5: hit = (x <= 22'h00ffff);
				3'h6: hit = (x <= 22'h1fffff);
				3'h7: hit = 1'b1;
				default: hit = 1'b0;
			endcase
		end
		return hit;
	endfunction : fsp_guarded

endpackage : fsp_pkg

// >>> hw/fsp_word_if.sv
`timescale 1ns/100ps
interface fsp_word_if;
	import fsp_pkg::*;
	logic [WORD_W-1:0] data;
	logic valid;
	logic ready;
	modport src (output data, output valid, input ready);
	modport snk (input data, input valid, output ready);
endinterface : fsp_word_if

// >>> hw/fsp_buf2.sv
`timescale 1ns/100ps
// Two-entry buffer; head and ready both come from flops
module fsp_buf2 import fsp_pkg::*;
(
	input logic core_clk,
	input logic rstn,
	fsp_word_if.snk in_p,
	fsp_word_if.src out_p
);
	logic [WORD_W-1:0] head;
	logic [WORD_W-1:0] spare;
	logic head_ok;
	logic spare_ok;
	logic push;
	logic pop;

	assign push = in_p.valid & ~spare_ok;
	assign pop = head_ok & out_p.ready;
	assign in_p.ready = ~spare_ok;
	assign out_p.data = head;
	assign out_p.valid = head_ok;

	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			head <= '0;
			spare <= '0;
			head_ok <= 1'b0;
			spare_ok <= 1'b0;
		end
		else if (pop)
		begin
			if (spare_ok)
			begin
				head <= spare;
				spare_ok <= 1'b0;
			end
			else if (push)
				head <= in_p.data;
			else
				head_ok <= 1'b0;
		end
		else if (push)
		begin
			if (!head_ok)
			begin
				head <= in_p.data;
				head_ok <= 1'b1;
			end
			else
			begin
				spare <= in_p.data;
				spare_ok <= 1'b1;
			end
		end
	end
endmodule : fsp_buf2

// >>> hw/fsp_ctrl.sv
`timescale 1ns/100ps
module fsp_ctrl import fsp_pkg::*;
#(
	parameter logic TOP_BOOT = 1'b0,
	parameter logic [7:0] DEV_ID = DEV_ID_DEF,
	parameter logic [23:0] PROG_CYC = PROG_CYC_DEF,
	parameter logic [23:0] SECT_CYC = SECT_CYC_DEF,
	parameter logic [23:0] BULK_CYC = BULK_CYC_DEF,
	parameter logic [23:0] STW_CYC = STW_CYC_DEF
)
(
	input logic core_clk,
	input logic rstn,
	input logic sclk,
	input logic select_n,
	input logic serial_in,
	input logic pause_n,
	input logic protect_n,
	output logic serial_out,
	output logic serial_out_oe,
	output logic [WORD_W-1:0] arr_word,
	output logic arr_valid,
	input logic arr_ready,
	output logic erase_req,
	output logic erase_all,
	output logic erase_otp,
	output logic [23:0] erase_addr,
	output fsp_pwr_t pwr_state
);
	////////////////////////////////////////////////////////////////////////
	// Pin synchronisers
	logic [SYNC_N-1:0] raw;
	logic [SYNC_N-1:0] s1;
	logic [SYNC_N-1:0] s2;
	assign raw = {protect_n, pause_n, serial_in, select_n, sclk};

	genvar gi;
	generate
		for (gi = 0; gi < SYNC_N; gi++)
		begin : g_sync
			always_ff @(posedge core_clk or negedge rstn)
			begin
				if (!rstn)
				begin
					s1[gi] <= SYNC_INIT[gi];
					s2[gi] <= SYNC_INIT[gi];
				end
				else
				begin
					s1[gi] <= raw[gi];
					s2[gi] <= s1[gi];
				end
			end
		end
	endgenerate

	logic sclk_prev;
	logic sel_prev;
	logic sel;
	logic sclk_rise;
	logic sclk_fall;
	logic cs_rise;
	assign sel = ~s2[SY_SEL];
	// Only edges matter, so either idle clock level is fine
	assign sclk_rise = s2[SY_CLK] & ~sclk_prev;
	assign sclk_fall = ~s2[SY_CLK] & sclk_prev;
	assign cs_rise = sel_prev & ~sel;

	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			sclk_prev <= 1'b0;
			sel_prev <= 1'b0;
		end
		else
		begin
			sclk_prev <= s2[SY_CLK];
			sel_prev <= sel;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Pause handling
	logic paused;
	logic hold_block;
	logic live;
	assign live = sel & ~paused & ~hold_block;

	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
			paused <= 1'b0;
		else if (!sel)
			paused <= 1'b0;
		else if (!paused && !s2[SY_PAUSE] && !s2[SY_CLK])
			paused <= 1'b1;
		else if (paused && s2[SY_PAUSE] && !s2[SY_CLK])
			paused <= 1'b0;
	end

	// Deselect in pause drops the frame; stays deaf until pause is released
	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
			hold_block <= 1'b0;
		else if (cs_rise && paused)
			hold_block <= 1'b1;
		else if (s2[SY_PAUSE])
			hold_block <= 1'b0;
	end

	////////////////////////////////////////////////////////////////////////
	// Byte assembly
	logic [2:0] bit_cnt;
	logic [9:0] byte_cnt;
	logic [6:0] in_sr;
	logic [7:0] opcode;
	logic [7:0] stw_data;
	logic [23:0] addr;
	logic [7:0] wr_pos;
	logic [8:0] data_cnt;
	logic byte_done;
	logic [7:0] new_byte;
	logic pg_wr;
	logic [7:0] page_buf [PAGE_BYTES];
	fsp_cyc_t cyc;

	assign byte_done = live & sclk_rise & (bit_cnt == 3'h7);
	assign new_byte = {in_sr, s2[SY_DIN]};
	// A page frame sent while a stream runs must not overwrite the words in flight
	assign pg_wr = byte_done & (opcode == OP_PGW) & (byte_cnt >= LEN_RGC) & (cyc == CYC_IDLE);

	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			bit_cnt <= 3'h0;
			byte_cnt <= 10'h000;
			in_sr <= 7'h00;
			opcode <= 8'h00;
			stw_data <= 8'h00;
			addr <= 24'h000000;
			wr_pos <= 8'h00;
			data_cnt <= 9'h000;
		end
		else if (!sel)
		begin
			bit_cnt <= 3'h0;
			byte_cnt <= 10'h000;
			wr_pos <= 8'h00;
			data_cnt <= 9'h000;
		end
		else if (live && sclk_rise)
		begin
			bit_cnt <= bit_cnt + 3'h1;
			in_sr <= new_byte[6:0];
			if (byte_done)
			begin
				if (byte_cnt != LEN_MAX)
					byte_cnt <= byte_cnt + 10'h001;
				if (byte_cnt == 10'h000)
					opcode <= new_byte;
				if (byte_cnt >= LEN_OP && byte_cnt < LEN_RGC)
					addr <= {addr[15:0], new_byte};
				if (byte_cnt == LEN_OP)
					stw_data <= new_byte;
				if (pg_wr)
				begin
					wr_pos <= wr_pos + 8'h01;
					if (data_cnt != PAGE_FULL)
						data_cnt <= data_cnt + 9'h001;
				end
			end
		end
	end

	// Page bytes wrap inside the page
	always_ff @(posedge core_clk)
	begin
		if (pg_wr)
			page_buf[addr[7:0] + wr_pos] <= new_byte;
	end

	////////////////////////////////////////////////////////////////////////
	// Instruction decode at deselect
	logic write_permit_latch;
	logic write_in_progress;
	logic deep;
	logic otp_mode;
	logic otp_lock;
	logic lock;
	logic [2:0] guard;
	logic cmd_ok;
	logic awake;
	logic hard;
	logic region_ok;
	logic do_wps;
	logic do_wpc;
	logic do_slp;
	logic do_otp;
	logic do_wake;
	logic do_stw;
	logic do_pgw;
	logic do_rgc;
	logic do_wac;
	logic start;

	// Busy cycles run to the end untouched by pause
	assign cmd_ok = cs_rise & ~paused & ~hold_block & (bit_cnt == 3'h0)
		& (cyc == CYC_IDLE);
	assign awake = ~deep;
	assign hard = lock & ~s2[SY_PROT];
	assign region_ok = otp_mode ? ~otp_lock
		: ~fsp_guarded(addr, guard, TOP_BOOT);
	assign do_wps = cmd_ok & awake & (opcode == OP_WPS) & (byte_cnt == LEN_OP);
	assign do_wpc = cmd_ok & awake & (opcode == OP_WPC) & (byte_cnt == LEN_OP);
	assign do_slp = cmd_ok & awake & (opcode == OP_SLP) & (byte_cnt == LEN_OP);
	assign do_otp = cmd_ok & awake & (opcode == OP_OTP) & (byte_cnt == LEN_OP);
	assign do_wake = cmd_ok & deep & (opcode == OP_WAKE) & (byte_cnt >= LEN_OP);
	assign do_stw = cmd_ok & awake & write_permit_latch & (opcode == OP_STW) & (byte_cnt == LEN_STW)
		& (otp_mode | ~hard);
	assign do_pgw = cmd_ok & awake & write_permit_latch & (opcode == OP_PGW)
		& (byte_cnt >= LEN_PGW_MIN) & region_ok;
	assign do_rgc = cmd_ok & awake & write_permit_latch & (opcode == OP_RGC)
		& (byte_cnt == LEN_RGC) & region_ok;
	assign do_wac = cmd_ok & awake & write_permit_latch & (opcode == OP_WAC)
		& (byte_cnt == LEN_OP) & ~otp_mode & (guard == GUARD_RST);
	assign start = do_stw | do_pgw | do_rgc | do_wac;

	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
			write_permit_latch <= 1'b0;
		else if (cyc == CYC_DONE || do_wpc)
			write_permit_latch <= 1'b0;
		else if (do_wps)
			write_permit_latch <= 1'b1;
	end

	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
			deep <= 1'b0;
		else if (do_slp)
			deep <= 1'b1;
		else if (do_wake)
			deep <= 1'b0;
	end

	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
			otp_mode <= 1'b0;
		else if (do_otp)
			otp_mode <= 1'b1;
		else if (do_wpc)
			otp_mode <= 1'b0;
	end

	// Reset values stand in for the retained cells
	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			guard <= GUARD_RST;
			lock <= LOCK_RST;
			otp_lock <= LOCK_RST;
		end
		else if (do_stw && otp_mode)
			otp_lock <= 1'b1;
		else if (do_stw)
		begin
			guard <= stw_data[ST_GUARD +: 3];
			lock <= stw_data[ST_LOCK];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Internal cycle
	logic [23:0] timer;
	logic [8:0] k;
	logic [8:0] prog_cnt;
	logic [23:0] prog_addr;
	logic prog_otp;
	logic push;
	logic [7:0] prog_lo;
	fsp_word_if to_buf ();
	fsp_word_if from_buf ();

	assign prog_lo = prog_addr[7:0] + k[7:0];
	assign to_buf.valid = (cyc == CYC_STREAM);
	// Array cells only ever clear bits, so streamed bytes program 1 to 0
	assign to_buf.data = {prog_otp, prog_addr[23:8], prog_lo, page_buf[prog_lo]};
	assign push = to_buf.valid & to_buf.ready;
	assign arr_word = from_buf.data;
	assign arr_valid = from_buf.valid;
	assign from_buf.ready = arr_ready;

	fsp_buf2 u_buf (
		.core_clk(core_clk),
		.rstn(rstn),
		.in_p(to_buf),
		.out_p(from_buf)
	);

	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			cyc <= CYC_IDLE;
			timer <= 24'h000000;
			k <= 9'h000;
		end
		else
		begin
			case (cyc)
				CYC_IDLE:
				begin
					k <= 9'h000;
					if (do_pgw)
						cyc <= CYC_STREAM;
					else if (start)
					begin
						cyc <= CYC_TIMED;
						timer <= do_stw ? STW_CYC : (do_wac ? BULK_CYC : SECT_CYC);
					end
				end
				CYC_STREAM:
					if (push)
					begin
						k <= k + 9'h001;
						if (k == prog_cnt - 9'h001)
						begin
							cyc <= CYC_TIMED;
							timer <= PROG_CYC;
						end
					end
				CYC_TIMED:
					if (timer == 24'h000000)
						cyc <= CYC_DONE;
					else
						timer <= timer - 24'h000001;
				CYC_DONE:
					cyc <= CYC_IDLE;
				default:
					cyc <= CYC_IDLE;
			endcase
		end
	end

	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
			write_in_progress <= 1'b0;
		else if (start)
			write_in_progress <= 1'b1;
		else if (cyc == CYC_DONE)
			write_in_progress <= 1'b0;
	end

	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			prog_cnt <= 9'h000;
			prog_addr <= 24'h000000;
			prog_otp <= 1'b0;
			erase_req <= 1'b0;
			erase_all <= 1'b0;
			erase_otp <= 1'b0;
			erase_addr <= 24'h000000;
		end
		else
		begin
			erase_req <= do_rgc | do_wac;
			if (start)
			begin
				prog_cnt <= data_cnt;
				prog_addr <= addr;
				prog_otp <= otp_mode;
				erase_all <= do_wac;
				erase_otp <= otp_mode;
				erase_addr <= addr;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Read path and power state
	logic [7:0] status;
	logic [7:0] out_sr;
	logic rd_on;
	assign status = {otp_mode ? otp_lock : lock, 2'b00, guard, write_permit_latch, write_in_progress};

	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			out_sr <= 8'h00;
			rd_on <= 1'b0;
			serial_out <= 1'b0;
			serial_out_oe <= 1'b0;
		end
		else
		begin
			serial_out_oe <= live & rd_on;
			if (!sel)
				rd_on <= 1'b0;
			else if (byte_done)
			begin
				if ((byte_cnt == 10'h000 && new_byte == OP_RDST && awake)
					|| (byte_cnt != 10'h000 && opcode == OP_RDST && rd_on))
				begin
					rd_on <= 1'b1;
					out_sr <= status;
				end
				else if (opcode == OP_WAKE && byte_cnt >= LEN_ID_AT)
				begin
					rd_on <= 1'b1;
					out_sr <= DEV_ID;
				end
			end
			else if (live && sclk_fall)
			begin
				serial_out <= out_sr[7];
				out_sr <= {out_sr[6:0], 1'b0};
			end
		end
	end

	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
			pwr_state <= PWR_STANDBY;
		else if (deep)
			pwr_state <= PWR_SLEEP;
		else if (sel || cyc != CYC_IDLE)
			pwr_state <= PWR_ACTIVE;
		else
			pwr_state <= PWR_STANDBY;
	end

	////////////////////////////////////////////////////////////////////////
	// Checks
	a_pause_float: assert property (@(posedge core_clk) disable iff (!rstn)
		paused |=> !serial_out_oe) else $error("output driven in pause");
	a_out_on_fall: assert property (@(posedge core_clk) disable iff (!rstn)
		!sclk_fall |=> $stable(serial_out)) else $error("output moved off fall");
	a_permit_done: assert property (@(posedge core_clk) disable iff (!rstn)
		cyc == CYC_DONE |=> !write_permit_latch && !write_in_progress) else $error("permit kept after cycle");
	a_busy_start: assert property (@(posedge core_clk) disable iff (!rstn)
		start |=> write_in_progress && cyc != CYC_IDLE) else $error("busy not set");
	a_bound_reject: assert property (@(posedge core_clk) disable iff (!rstn)
		cs_rise && bit_cnt != 3'h0 && cyc == CYC_IDLE |=> cyc == CYC_IDLE && write_permit_latch == $past(write_permit_latch))
		else $error("unaligned instruction ran");
	a_sleep_deaf: assert property (@(posedge core_clk) disable iff (!rstn)
		deep && !(cs_rise && opcode == OP_WAKE) |=> deep && $stable(write_permit_latch))
		else $error("sleep left or permit changed");
	a_hard_freeze: assert property (@(posedge core_clk) disable iff (!rstn)
		hard && !otp_mode |=> $stable(guard) && $stable(lock))
		else $error("guard bits written under hard guard");
	a_otp_once: assert property (@(posedge core_clk) disable iff (!rstn)
		otp_lock |=> otp_lock ##1 otp_lock) else $error("area lock cleared");
	a_guard_block: assert property (@(posedge core_clk) disable iff (!rstn)
		cs_rise && !otp_mode && fsp_guarded(addr, guard, TOP_BOOT) && opcode == OP_RGC
		|=> !erase_req) else $error("guarded region erased");
	a_standby: assert property (@(posedge core_clk) disable iff (!rstn)
		!sel && !deep && cyc == CYC_IDLE |=> pwr_state != PWR_ACTIVE)
		else $error("no standby");
endmodule : fsp_ctrl

// >>> sim/fsp_spi_master.sv
`timescale 1ns/100ps
// Serial bus master; link clock moves inside frames, and before select falls only on a mode change
module fsp_spi_master
(
	output logic sclk,
	output logic select_n,
	output logic serial_in,
	input logic serial_out
);
	logic idle = 1'b0;
	logic [7:0] rx;
	initial
	begin
		sclk = 1'b0;
		select_n = 1'b1;
		serial_in = 1'b0;
	end
	////////////////////////////////////////////////////////////////////
	// Idle level 0 or 1 picks bus mode 0 or 3
	// Whole bytes, most significant bit first, then any extra single 1 bits
	task automatic frame(input logic [7:0] q[$], input int extra, input int rd);
		// Idle level settles before select falls, so a mode change makes no edge inside the frame
		sclk = idle;
		#400 select_n = 1'b0;
		#400;
		foreach (q[k])
			for (int i = 7; i >= 0; i--)
				shift(q[k][i]);
		repeat (extra)
			shift(1'b1);
		// Sample late in the high phase: output lags the pin fall by the sync
		repeat (rd * 8)
		begin
			sclk = 1'b0;
			#400 sclk = 1'b1;
			#390 rx = {rx[6:0], serial_out};
			#10;
		end
		sclk = idle;
		#400 select_n = 1'b1;
		// Released line must not keep its last value
		serial_in = ~serial_in;
		#1200;
	endtask : frame
	task automatic shift(input logic b);
		sclk = 1'b0;
		serial_in = b;
		#400 sclk = 1'b1;
		#400;
	endtask : shift
endmodule : fsp_spi_master

// >>> sim/testbench.sv
`timescale 1ns/100ps
module testbench;
	import fsp_pkg::*;
	logic core_clk = 1'b0;
	logic rstn = 1'b0;
	logic pause_n = 1'b1;
	logic protect_n = 1'b1;
	logic arr_ready = 1'b0;
	wire sclk, select_n, serial_in, serial_out, serial_out_oe, arr_valid;
	wire erase_req, erase_all, erase_otp;
	wire so_line;
	wire [WORD_W-1:0] arr_word;
	wire [23:0] erase_addr;
	fsp_pwr_t pwr_state;
	logic [23:0] ea;
	logic [1:0] ef;
	logic [23:0] a;
	logic [7:0] q[$];
	logic [WORD_W-1:0] exp_q[$];
	int err_total = 0;
	int total_checks = 0;
	int n_er = 0;
	int m_er = 0;
	int cyc = 0;
	int seed = 82203;
	int n;
	int lim[8] = '{-1, 'hfff, 'h1fff, 'h3fff, 'h7fff, 'hffff, 'h1fffff, 'h3fffff};
	always #50 core_clk = ~core_clk;
	fsp_spi_master fsp_spi_master_i (.sclk(sclk), .select_n(select_n), .serial_in(serial_in),
		.serial_out(so_line));
	// A released data line shows the inverse of its last value
	assign so_line = serial_out_oe ? serial_out : ~serial_out;
	// Long erase so busy is visible to a serial status read
	fsp_ctrl #(.PROG_CYC(24'h000004), .SECT_CYC(24'h000400), .BULK_CYC(24'h000008),
		.STW_CYC(24'h000004)) fsp_ctrl_i (.core_clk(core_clk), .rstn(rstn), .sclk(sclk),
		.select_n(select_n), .serial_in(serial_in), .pause_n(pause_n), .protect_n(protect_n),
		.serial_out(serial_out), .serial_out_oe(serial_out_oe), .arr_word(arr_word),
		.arr_valid(arr_valid), .arr_ready(arr_ready), .erase_req(erase_req),
		.erase_all(erase_all), .erase_otp(erase_otp), .erase_addr(erase_addr),
		.pwr_state(pwr_state));
	////////////////////////////////////////////////////////////////////
	task automatic check(input logic [32:0] seen, input logic [32:0] expv);
		total_checks++;
		if (seen !== expv)
		begin
			err_total++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, expv);
		end
	endtask : check
	task automatic conclude();
		$display("checks=%0d errors=%0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : conclude
	task automatic send(input int extra, input int rd);
		fsp_spi_master_i.frame(q, extra, rd);
	endtask : send
	task automatic op(input logic [7:0] c);
		q = {c};
		send(0, 0);
	endtask : op
	task automatic rd_st(output logic [7:0] s);
		q = {OP_RDST};
		send(0, 1);
		s = fsp_spi_master_i.rx;
	endtask : rd_st
	task automatic poll();
		logic [7:0] s;
		s = 8'h01;
		for (int i = 0; i < 40 && s[ST_WIP] !== 1'b0; i++)
			rd_st(s);
		check(33'(s[ST_WIP]), 33'h0);
	endtask : poll
	task automatic erase(input int x);
		q = {OP_RGC, 8'(x >> 16), 8'(x >> 8), 8'(x)};
		send(0, 0);
	endtask : erase
	////////////////////////////////////////////////////////////////////
	// Array side stalls at random; every accepted word must be expected
	always @(posedge core_clk)
	begin
		cyc++;
		arr_ready <= 1'($random(seed));
		if (arr_valid === 1'b1 && arr_ready)
		begin
			if (exp_q.size() == 0)
				check(arr_word, ~arr_word);
			else
				check(arr_word, exp_q.pop_front());
		end
		if (erase_req === 1'b1)
		begin
			n_er++;
			ea = erase_addr;
			ef = {erase_all, erase_otp};
		end
		if (cyc == 80000)
		begin
			err_total++;
			conclude();
		end
	end
	initial
	begin
		logic [7:0] s;
		logic [7:0] d;
		repeat (12) @(posedge core_clk);
		rstn <= 1'b1;
		repeat (3) @(posedge core_clk);
		check(33'(pwr_state), 33'(PWR_STANDBY));
		rd_st(s);
		check(33'(s), 33'h0);
		for (int m = 0; m < 2; m++)
		begin
			fsp_spi_master_i.idle = m[0];
			op(OP_WPS);
			rd_st(s);
			check(33'(s), 33'h2);
			op(OP_WPC);
			rd_st(s);
			check(33'(s), 33'h0);
		end
		fsp_spi_master_i.idle = 1'b0;
		// Random page program, start address picked so the stream may wrap
		op(OP_WPS);
		a = {16'h0040, 8'($random(seed))};
		n = 1 + ({$random(seed)} % 20);
		q = {OP_PGW, a[23:16], a[15:8], a[7:0]};
		for (int i = 0; i < n; i++)
		begin
			d = 8'($random(seed));
			q.push_back(d);
			exp_q.push_back({1'b0, a[23:8], 8'(a[7:0] + i[7:0]), d});
		end
		send(0, 0);
		for (int i = 0; i < 500 && exp_q.size() > 0; i++)
			@(posedge core_clk);
		check(33'(exp_q.size()), 33'h0);
		poll();
		rd_st(s);
		check(33'(s), 33'h0);
		// Trailing partial byte: nothing written, permit kept
		op(OP_WPS);
		q = {OP_WPC};
		send(3, 0);
		rd_st(s);
		check(33'(s), 33'h2);
		op(OP_WPC);
		for (int g = 0; g < 8; g++)
		begin
			op(OP_WPS);
			q = {OP_STW, 8'(g << 2)};
			send(0, 0);
			poll();
			rd_st(s);
			check(33'(s), 33'(g << 2));
			if (g > 0)
			begin
				op(OP_WPS);
				erase(lim[g]);
				check(33'(n_er), 33'(m_er));
				op(OP_WPC);
			end
			if (g < 7)
			begin
				op(OP_WPS);
				erase(lim[g] + 1);
				m_er++;
				rd_st(s);
				check(33'(s), 33'((g << 2) | 3));
				check(33'(pwr_state), 33'(PWR_ACTIVE));
				poll();
				check(33'(n_er), 33'(m_er));
				check(33'(ea), 33'(lim[g] + 1));
				check(33'(ef), 33'h0);
				check(33'(pwr_state), 33'(PWR_STANDBY));
			end
		end
		op(OP_WPS);
		q = {OP_STW, 8'h00};
		send(0, 0);
		poll();
		// One-time sector: erase while open, then seal it
		op(OP_OTP);
		op(OP_WPS);
		erase(0);
		m_er++;
		poll();
		check(33'(n_er), 33'(m_er));
		check(33'(ef), 33'h1);
		op(OP_WPS);
		q = {OP_STW, 8'h1c};
		send(0, 0);
		poll();
		rd_st(s);
		check(33'(s), 33'h80);
		op(OP_WPS);
		erase(0);
		check(33'(n_er), 33'(m_er));
		op(OP_WPC);
		rd_st(s);
		check(33'(s), 33'h0);
		// Whole array clear with no guard bits set
		op(OP_WPS);
		op(OP_WAC);
		m_er++;
		poll();
		check(33'(n_er), 33'(m_er));
		check(33'(ef), 33'h2);
		// Lock bit plus protect pin freezes the guard and lock bits
		op(OP_WPS);
		q = {OP_STW, 8'h80};
		send(0, 0);
		poll();
		@(posedge core_clk) protect_n <= 1'b0;
		op(OP_WPS);
		q = {OP_STW, 8'h1c};
		send(0, 0);
		rd_st(s);
		check(33'(s), 33'h82);
		@(posedge core_clk) protect_n <= 1'b1;
		q = {OP_STW, 8'h00};
		send(0, 0);
		poll();
		// Frame sent in pause is dropped; deselect in pause needs a release first
		@(posedge core_clk) pause_n <= 1'b0;
		op(OP_WPS);
		@(posedge core_clk) pause_n <= 1'b1;
		rd_st(s);
		check(33'(s), 33'h0);
		op(OP_WPS);
		rd_st(s);
		check(33'(s), 33'h2);
		op(OP_WPC);
		op(OP_SLP);
		check(33'(pwr_state), 33'(PWR_SLEEP));
		op(OP_WPS);
		op(OP_WAKE);
		check(33'(pwr_state), 33'(PWR_STANDBY));
		rd_st(s);
		check(33'(s), 33'h0);
		conclude();
	end
endmodule : testbench
